//--- inc/pcr_pkg.sv
package pcr_pkg;
    // register addresses
    localparam logic [7:0] ADDR_SYSTEM_MODE      = 8'hDF;
    localparam logic [7:0] ADDR_PWM_CONTROL      = 8'hE3;
    localparam logic [7:0] ADDR_STOP_ENABLE_KEY  = 8'hE4;
    localparam logic [7:0] ADDR_PORT_ONE_CONTROL = 8'hE9;
    localparam logic [7:0] ADDR_PORT_TWO_HIGH    = 8'hEA;
    localparam logic [7:0] ADDR_PORT_TWO_LOW     = 8'hEB;
    localparam logic [7:0] ADDR_TIMER_ZERO       = 8'hF4;
    // implemented-bit masks
    localparam logic [7:0] MASK_SYSTEM_MODE      = 8'h0F;
    localparam logic [7:0] MASK_PWM_CONTROL      = 8'hDF;
    localparam logic [7:0] MASK_STOP_ENABLE_KEY  = 8'hFF;
    localparam logic [7:0] MASK_PORT_ONE_CONTROL = 8'hCF;
    localparam logic [7:0] MASK_PORT_TWO_HIGH    = 8'h7F;
    localparam logic [7:0] MASK_PORT_TWO_LOW     = 8'hFF;
    localparam logic [7:0] MASK_TIMER_ZERO       = 8'hCB;
    localparam logic [7:0] RESET_VALUE           = 8'h00;
    // field positions
    localparam int BIT_GLOBAL_IE   = 3;
    localparam int BIT_PRESC_HI    = 7;
    localparam int BIT_PRESC_LO    = 6;
    localparam int BIT_RELOAD_SEL  = 4;
    localparam int BIT_CNT_CLEAR   = 3;
    localparam int BIT_CNT_ENABLE  = 2;
    localparam int BIT_INT_ENABLE  = 1;
    localparam int BIT_INT_PENDING = 0;
    localparam int BIT_P1_OD_ONE   = 7;
    localparam int BIT_P1_OD_ZERO  = 6;
    localparam logic [7:0] STOP_KEY = 8'hA5;
    // divider ratios
    localparam logic [12:0] PWM_DIV_00 = 13'h0040;
    localparam logic [12:0] PWM_DIV_01 = 13'h0008;
    localparam logic [12:0] PWM_DIV_10 = 13'h0002;
    localparam logic [12:0] PWM_DIV_11 = 13'h0001;
    localparam logic [12:0] TMR_DIV_00 = 13'h1000;
    localparam logic [12:0] TMR_DIV_01 = 13'h0100;
    localparam logic [12:0] TMR_DIV_10 = 13'h0008;
    localparam logic [12:0] TMR_DIV_11 = 13'h0001;
    // two-bit pin modes, port 1
    localparam logic [1:0] P1_INPUT     = 2'h0;
    localparam logic [1:0] P1_PULL_UP   = 2'h1;
    localparam logic [1:0] P1_OUTPUT    = 2'h2;
    localparam logic [1:0] P1_PULL_DOWN = 2'h3;
    // two-bit pin modes, port 2
    localparam logic [1:0] P2_PULL_UP   = 2'h0;
    localparam logic [1:0] P2_INPUT     = 2'h1;
    localparam logic [1:0] P2_PUSH_PULL = 2'h2;
    localparam logic [1:0] P2_OPEN_OR_T = 2'h3;
    // three-bit pin six modes
    localparam logic [2:0] P6_PULL_UP   = 3'h0;
    localparam logic [2:0] P6_INPUT     = 3'h1;
    localparam logic [2:0] P6_PUSH_PULL = 3'h4;
    localparam logic [2:0] P6_OD_PULL   = 3'h5;
    localparam logic [2:0] P6_OPEN      = 3'h6;
    localparam logic [2:0] P6_CLOCK_OUT = 3'h7;
endpackage

//--- verilog/pcr_pin_cfg.sv
`timescale 1ns/1ps
// decodes one two-bit port-2 mode field
module pcr_pin_cfg
    import pcr_pkg::*;
#(
    parameter bit TIMER_ALT = 1'b0
) (
    // mode
    input  wire logic [1:0] mode,
    // decoded pin controls
    output logic            pull_up,
    output logic            drive_en,
    output logic            open_drain,
    output logic            timer_out
);
    always_comb begin
        pull_up    = 1'b0;
        drive_en   = 1'b0;
        open_drain = 1'b0;
        timer_out  = 1'b0;
        unique case (mode)
            P2_PULL_UP:   pull_up = 1'b1;
            P2_INPUT:     pull_up = 1'b0;
            P2_PUSH_PULL: drive_en = 1'b1;
            P2_OPEN_OR_T: begin
                drive_en = 1'b1;
                if (TIMER_ALT) begin
                    timer_out = 1'b1;
                end else begin
                    open_drain = 1'b1;
                end
            end
        endcase
    end
endmodule

//--- verilog/pcr_div.sv
`timescale 1ns/1ps
// programmable prescaler, one tick per ratio clocks
module pcr_div
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // control
    input  wire logic [12:0] ratio,
    // tick
    output logic             tick
);
    logic [12:0] cnt_r;
    logic [12:0] cnt_nxt;
    logic        tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r + 13'h0001;
        tick_nxt = 1'b0;
        if (cnt_nxt >= ratio) begin
            cnt_nxt  = 13'h0000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= 13'h0000;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule

//--- verilog/pcr_bank.sv
`timescale 1ns/1ps
module pcr_bank
    import pcr_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // register file access
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // core events
    input  wire logic       int_ack,
    input  wire logic       int_return,
    input  wire logic       stop_exec,
    input  wire logic       pwm_overflow8,
    input  wire logic       pwm_overflow6,
    input  wire logic       timer_match,
    // core controls
    output logic            global_int_en,
    output logic      [2:0] page_select,
    output logic            stop_enter,
    output logic            stop_to_reset,
    output logic            pwm_irq,
    output logic            timer_irq,
    // counter controls
    output logic            pwm_tick,
    output logic            pwm_clear,
    output logic            pwm_run,
    output logic            pwm_duty_reload,
    output logic            timer_tick,
    output logic            timer_clear,
    // port one pins
    output logic      [1:0] p1_pull_up,
    output logic      [1:0] p1_pull_down,
    output logic      [1:0] p1_drive_en,
    output logic      [1:0] p1_open_drain,
    // port two pins
    output logic      [6:0] p2_pull_up,
    output logic      [6:0] p2_drive_en,
    output logic      [6:0] p2_open_drain,
    output logic            p2_analog_eight,
    output logic            p2_clock_out,
    output logic            p2_timer_out
);
    logic [7:0] sym_r, sym_nxt;
    logic [7:0] pwm_r, pwm_nxt;
    logic [7:0] key_r, key_nxt;
    logic [7:0] p1_r, p1_nxt;
    logic [7:0] p2h_r, p2h_nxt;
    logic [7:0] p2l_r, p2l_nxt;
    logic [7:0] t0_r, t0_nxt;
    logic [7:0] rdata_nxt;
    logic       wr_sym, wr_pwm, wr_key, wr_p1, wr_p2h, wr_p2l, wr_t0;
    logic [12:0] pwm_ratio, tmr_ratio;
    logic        pwm_div_tick, tmr_div_tick;
    logic [5:0]  pu_c, de_c, od_c;
    logic        t0_alt_c;
    logic [1:0]  p1_pu_c, p1_pd_c, p1_de_c, p1_od_c;
    logic        p6_an_c, p6_clk_c, pu6_c, de6_c, od6_c;
    logic        gie_c, stop_en_c, stop_rst_c;

    // register writes, one byte per location
    always_comb begin
        wr_sym = reg_wr && (reg_addr == ADDR_SYSTEM_MODE);
        wr_pwm = reg_wr && (reg_addr == ADDR_PWM_CONTROL);
        wr_key = reg_wr && (reg_addr == ADDR_STOP_ENABLE_KEY);
        wr_p1  = reg_wr && (reg_addr == ADDR_PORT_ONE_CONTROL);
        wr_p2h = reg_wr && (reg_addr == ADDR_PORT_TWO_HIGH);
        wr_p2l = reg_wr && (reg_addr == ADDR_PORT_TWO_LOW);
        wr_t0  = reg_wr && (reg_addr == ADDR_TIMER_ZERO);
    end

    always_comb begin
        sym_nxt = sym_r;
        if (wr_sym) begin
            sym_nxt = reg_wdata & MASK_SYSTEM_MODE;
        end
        // hardware acknowledge/return act after a software write
        if (int_ack) begin
            sym_nxt[BIT_GLOBAL_IE] = 1'b0;
        end else if (int_return) begin
            sym_nxt[BIT_GLOBAL_IE] = 1'b1;
        end

        pwm_nxt = pwm_r;
        if (wr_pwm) begin
            pwm_nxt = reg_wdata & MASK_PWM_CONTROL;
            // pending only cleared by writing 0
            pwm_nxt[BIT_INT_PENDING] = pwm_r[BIT_INT_PENDING]
                                       & reg_wdata[BIT_INT_PENDING];
        end
        if (pwm_overflow8) begin
            pwm_nxt[BIT_INT_PENDING] = 1'b1;
        end

        t0_nxt = t0_r;
        if (wr_t0) begin
            t0_nxt = reg_wdata & MASK_TIMER_ZERO;
            t0_nxt[BIT_INT_PENDING] = t0_r[BIT_INT_PENDING]
                                      & reg_wdata[BIT_INT_PENDING];
        end
        if (timer_match) begin
            t0_nxt[BIT_INT_PENDING] = 1'b1;
        end

        key_nxt = wr_key ? (reg_wdata & MASK_STOP_ENABLE_KEY) : key_r;
        p1_nxt  = wr_p1  ? (reg_wdata & MASK_PORT_ONE_CONTROL) : p1_r;
        p2h_nxt = wr_p2h ? (reg_wdata & MASK_PORT_TWO_HIGH) : p2h_r;
        p2l_nxt = wr_p2l ? (reg_wdata & MASK_PORT_TWO_LOW) : p2l_r;
    end

    // read mux, unmapped reads zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SYSTEM_MODE:      rdata_nxt = sym_r;
                ADDR_PWM_CONTROL:      rdata_nxt = pwm_r;
                ADDR_STOP_ENABLE_KEY:  rdata_nxt = key_r;
                ADDR_PORT_ONE_CONTROL: rdata_nxt = p1_r;
                ADDR_PORT_TWO_HIGH:    rdata_nxt = p2h_r;
                ADDR_PORT_TWO_LOW:     rdata_nxt = p2l_r;
                ADDR_TIMER_ZERO:       rdata_nxt = t0_r;
                default:               rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sym_r     <= RESET_VALUE;
            pwm_r     <= RESET_VALUE;
            key_r     <= RESET_VALUE;
            p1_r      <= RESET_VALUE;
            p2h_r     <= RESET_VALUE;
            p2l_r     <= RESET_VALUE;
            t0_r      <= RESET_VALUE;
            reg_rdata <= 8'h00;
        end else begin
            sym_r     <= sym_nxt;
            pwm_r     <= pwm_nxt;
            key_r     <= key_nxt;
            p1_r      <= p1_nxt;
            p2h_r     <= p2h_nxt;
            p2l_r     <= p2l_nxt;
            t0_r      <= t0_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // prescaler selection
    always_comb begin
        unique case (pwm_r[BIT_PRESC_HI:BIT_PRESC_LO])
            2'h0: pwm_ratio = PWM_DIV_00;
            2'h1: pwm_ratio = PWM_DIV_01;
            2'h2: pwm_ratio = PWM_DIV_10;
            2'h3: pwm_ratio = PWM_DIV_11;
        endcase
        unique case (t0_r[BIT_PRESC_HI:BIT_PRESC_LO])
            2'h0: tmr_ratio = TMR_DIV_00;
            2'h1: tmr_ratio = TMR_DIV_01;
            2'h2: tmr_ratio = TMR_DIV_10;
            2'h3: tmr_ratio = TMR_DIV_11;
        endcase
    end

    pcr_div u_pwm_div (
        .core_clk (core_clk),
        .rst      (rst),
        .ratio    (pwm_ratio),
        .tick     (pwm_div_tick)
    );

    pcr_div u_tmr_div (
        .core_clk (core_clk),
        .rst      (rst),
        .ratio    (tmr_ratio),
        .tick     (tmr_div_tick)
    );

    // port two pins zero to five
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_p2
            logic [1:0] mode_c;
            logic       to_c;
            if (g < 4) begin : g_lo
                assign mode_c = p2l_r[2*g+1:2*g];
            end else begin : g_hi
                assign mode_c = p2h_r[2*(g-4)+1:2*(g-4)];
            end
            pcr_pin_cfg #(.TIMER_ALT(g == 0)) u_pin (
                .mode       (mode_c),
                .pull_up    (pu_c[g]),
                .drive_en   (de_c[g]),
                .open_drain (od_c[g]),
                .timer_out  (to_c)
            );
            if (g == 0) begin : g_t0
                assign t0_alt_c = to_c;
            end
        end
    endgenerate

    // pin six and port one decode
    always_comb begin
        pu6_c    = 1'b0;
        de6_c    = 1'b0;
        od6_c    = 1'b0;
        p6_an_c  = 1'b0;
        p6_clk_c = 1'b0;
        unique casez (p2h_r[6:4])
            P6_PULL_UP:   pu6_c = 1'b1;
            P6_INPUT:     pu6_c = 1'b0;
            3'b01?:       p6_an_c = 1'b1;
            P6_PUSH_PULL: de6_c = 1'b1;
            P6_OD_PULL: begin
                de6_c = 1'b1;
                od6_c = 1'b1;
                pu6_c = 1'b1;
            end
            P6_OPEN: begin
                de6_c = 1'b1;
                od6_c = 1'b1;
            end
            P6_CLOCK_OUT: begin
                de6_c    = 1'b1;
                p6_clk_c = 1'b1;
            end
        endcase
        for (int i = 0; i < 2; i++) begin
            p1_pu_c[i] = (p1_r[2*i +: 2] == P1_PULL_UP);
            p1_pd_c[i] = (p1_r[2*i +: 2] == P1_PULL_DOWN);
            p1_de_c[i] = (p1_r[2*i +: 2] == P1_OUTPUT);
        end
        p1_od_c[1] = p1_r[BIT_P1_OD_ONE];
        p1_od_c[0] = p1_r[BIT_P1_OD_ZERO];
        gie_c      = sym_r[BIT_GLOBAL_IE];
        stop_en_c  = stop_exec && (key_r == STOP_KEY);
        stop_rst_c = stop_exec && (key_r != STOP_KEY);
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            global_int_en   <= 1'b0;
            page_select     <= 3'h0;
            stop_enter      <= 1'b0;
            stop_to_reset   <= 1'b0;
            pwm_irq         <= 1'b0;
            timer_irq       <= 1'b0;
            pwm_tick        <= 1'b0;
            pwm_clear       <= 1'b0;
            pwm_run         <= 1'b0;
            pwm_duty_reload <= 1'b0;
            timer_tick      <= 1'b0;
            timer_clear     <= 1'b0;
            p1_pull_up      <= 2'h0;
            p1_pull_down    <= 2'h0;
            p1_drive_en     <= 2'h0;
            p1_open_drain   <= 2'h0;
            p2_pull_up      <= 7'h00;
            p2_drive_en     <= 7'h00;
            p2_open_drain   <= 7'h00;
            p2_analog_eight <= 1'b0;
            p2_clock_out    <= 1'b0;
            p2_timer_out    <= 1'b0;
        end else begin
            global_int_en   <= gie_c;
            page_select     <= sym_r[2:0];
            stop_enter      <= stop_en_c;
            stop_to_reset   <= stop_rst_c;
            pwm_irq         <= pwm_r[BIT_INT_ENABLE]
                               & pwm_r[BIT_INT_PENDING];
            timer_irq       <= t0_r[BIT_INT_ENABLE]
                               & t0_r[BIT_INT_PENDING];
            pwm_tick        <= pwm_div_tick & pwm_r[BIT_CNT_ENABLE];
            pwm_clear       <= pwm_r[BIT_CNT_CLEAR];
            pwm_run         <= pwm_r[BIT_CNT_ENABLE];
            pwm_duty_reload <= pwm_r[BIT_RELOAD_SEL] ? pwm_overflow6
                                                     : pwm_overflow8;
            timer_tick      <= tmr_div_tick;
            timer_clear     <= t0_r[BIT_CNT_CLEAR];
            p1_pull_up      <= p1_pu_c;
            p1_pull_down    <= p1_pd_c;
            p1_drive_en     <= p1_de_c;
            p1_open_drain   <= p1_od_c;
            p2_pull_up      <= {pu6_c, pu_c};
            p2_drive_en     <= {de6_c, de_c};
            p2_open_drain   <= {od6_c, od_c};
            p2_analog_eight <= p6_an_c;
            p2_clock_out    <= p6_clk_c;
            // match output needs counter-clear bit set as well
            p2_timer_out    <= t0_alt_c & t0_r[BIT_CNT_CLEAR];
        end
    end
endmodule

//--- verification/pcr_core_model.sv
`timescale 1ns/1ps
// core side of the register file, drives on the falling edge
module pcr_core_model (
    // clock
    input  wire logic       core_clk,
    // register file access
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // idle bus never shows the last value
    task automatic idle_bus();
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        idle_bus();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        idle_bus();
    endtask
endmodule

//--- verification/pcr_bank_assertions.sv
`timescale 1ns/1ps
module pcr_bank_assertions
    import pcr_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       int_ack,
    input wire logic       int_return,
    input wire logic       stop_exec,
    input wire logic       global_int_en,
    input wire logic [2:0] page_select,
    input wire logic       stop_enter,
    input wire logic       stop_to_reset,
    input wire logic       pwm_run,
    input wire logic       pwm_clear
);
    logic modew;
    logic pwmw;
    assign modew = reg_wr && (reg_addr == ADDR_SYSTEM_MODE);
    assign pwmw = reg_wr && (reg_addr == ADDR_PWM_CONTROL);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_STOP_ONE: assert property
        (stop_exec |=> stop_enter ^ stop_to_reset)
        else $error("stop outcome not exactly one");
    AST_STOP_NONE: assert property
        (!stop_exec |=> !stop_enter && !stop_to_reset)
        else $error("stop outcome without stop");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    AST_UNUSED: assert property
        (reg_rd && reg_addr == ADDR_SYSTEM_MODE |=> reg_rdata[7:4] == 4'h0)
        else $error("unused mode bits read nonzero");
    AST_KEY_RW: assert property
        (reg_wr && reg_addr == ADDR_STOP_ENABLE_KEY ##1 !reg_wr
         ##1 (reg_rd && !reg_wr && reg_addr == ADDR_STOP_ENABLE_KEY)
         |=> reg_rdata == $past(reg_wdata, 3))
        else $error("key readback differs");
    AST_ACK: assert property
        (int_ack ##1 (!int_return && !modew) |=> !global_int_en)
        else $error("ack left global enable set");
    AST_RET: assert property
        (int_return && !int_ack ##1 (!int_ack && !modew) |=> global_int_en)
        else $error("return left global enable clear");
    AST_PAGE: assert property
        (modew ##1 !modew |=> page_select == $past(reg_wdata[2:0], 2))
        else $error("page select differs from write");
    AST_RUN: assert property
        (pwmw ##1 !pwmw |=> pwm_run == $past(reg_wdata[2], 2)
         && pwm_clear == $past(reg_wdata[3], 2))
        else $error("pwm run or clear differs from write");
    cover property (stop_exec ##1 stop_enter);
    cover property (stop_exec ##1 stop_to_reset);
    cover property (int_ack ##2 !global_int_en);
endmodule
bind pcr_bank pcr_bank_assertions u_chk (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .int_ack(int_ack), .int_return(int_return),
    .stop_exec(stop_exec), .global_int_en(global_int_en),
    .page_select(page_select), .stop_enter(stop_enter),
    .stop_to_reset(stop_to_reset), .pwm_run(pwm_run),
    .pwm_clear(pwm_clear));

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pcr_pkg::*;
    logic       core_clk, rst, reg_wr, reg_rd, global_int_en;
    logic       stop_enter, stop_to_reset, pwm_irq, timer_irq;
    logic       pwm_tick, pwm_clear, pwm_run, pwm_duty_reload;
    logic       timer_tick, timer_clear, p2_analog_eight;
    logic       p2_clock_out, p2_timer_out, od;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, a;
    logic [5:0] ev;
    logic [2:0] page_select;
    logic [1:0] p1_pull_up, p1_pull_down, p1_drive_en, p1_open_drain, m;
    logic [6:0] p2_pull_up, p2_drive_en, p2_open_drain;
    int         miscompares, tests_run, cyc, se, sr, dr, ic;
    localparam logic [7:0] ADR [7] = '{ADDR_SYSTEM_MODE, ADDR_PWM_CONTROL,
        ADDR_STOP_ENABLE_KEY, ADDR_PORT_ONE_CONTROL, ADDR_PORT_TWO_HIGH,
        ADDR_PORT_TWO_LOW, ADDR_TIMER_ZERO};
    // pending bits cannot be set by software
    localparam logic [7:0] MSK [7] = '{8'h0F, 8'hDE, 8'hFF, 8'hCF, 8'h7F,
        8'hFF, 8'hCA};
    localparam logic [7:0] KEYS [4] = '{8'h00, 8'hA4, 8'hA5, 8'hB5};
    localparam logic [15:0] PDIV [4] = '{16'h0040, 16'h0008, 16'h0002,
        16'h0001};
    localparam logic [15:0] TDIV [4] = '{16'h1000, 16'h0100, 16'h0008,
        16'h0001};
    pcr_core_model u_core (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    pcr_bank u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .int_ack(ev[0]), .int_return(ev[1]),
        .stop_exec(ev[2]), .pwm_overflow8(ev[3]), .pwm_overflow6(ev[4]),
        .timer_match(ev[5]), .global_int_en(global_int_en),
        .page_select(page_select), .stop_enter(stop_enter),
        .stop_to_reset(stop_to_reset), .pwm_irq(pwm_irq),
        .timer_irq(timer_irq), .pwm_tick(pwm_tick), .pwm_clear(pwm_clear),
        .pwm_run(pwm_run), .pwm_duty_reload(pwm_duty_reload),
        .timer_tick(timer_tick), .timer_clear(timer_clear),
        .p1_pull_up(p1_pull_up), .p1_pull_down(p1_pull_down),
        .p1_drive_en(p1_drive_en), .p1_open_drain(p1_open_drain),
        .p2_pull_up(p2_pull_up), .p2_drive_en(p2_drive_en),
        .p2_open_drain(p2_open_drain), .p2_analog_eight(p2_analog_eight),
        .p2_clock_out(p2_clock_out), .p2_timer_out(p2_timer_out));
    always #2.5 core_clk = ~core_clk;
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e,
                          input string nm);
        logic [7:0] v;
        u_core.rd(ad, v);
        chk(nm, e, v);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // one event pulse, outcome pulses counted over four cycles
    task automatic fire(input int k);
        se = 0;
        sr = 0;
        dr = 0;
        @(negedge core_clk);
        ev[k] = 1'b1;
        repeat (4) begin
            @(negedge core_clk);
            ev = 6'h00;
            se += (stop_enter === 1'b1);
            sr += (stop_to_reset === 1'b1);
            dr += (pwm_duty_reload === 1'b1);
        end
    endtask
    // third interval, after the old ratio has wrapped
    task automatic meas(input int sel, input logic [15:0] e);
        int n;
        repeat (3) begin
            n = 0;
            do begin
                @(negedge core_clk);
                n++;
            end while (((sel ? timer_tick : pwm_tick) !== 1'b1) && n < 9000);
        end
        chk("tick period", e, n[15:0]);
    endtask
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        ev = 6'h00;
        miscompares = 0;
        tests_run = 0;
        idle(16);
        rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd_chk(ADR[i], RESET_VALUE, "reset value");
            u_core.wr(ADR[i], 8'hFF);
            rd_chk(ADR[i], MSK[i], "masked readback");
            u_core.wr(ADR[i], 8'h00);
        end
        u_core.wr(8'hE5, 8'hFF);
        rd_chk(8'hE5, 8'h00, "unmapped");
        u_core.wr(ADDR_SYSTEM_MODE, 8'h0B);
        idle(3);
        chk("global enable", 1, global_int_en);
        chk("page", 3, page_select);
        fire(0);
        chk("ack clears enable", 0, global_int_en);
        rd_chk(ADDR_SYSTEM_MODE, 8'h03, "mode after ack");
        fire(1);
        chk("return sets enable", 1, global_int_en);
        u_core.wr(ADDR_SYSTEM_MODE, 8'h00);
        idle(3);
        chk("global disable", 0, global_int_en);
        for (int i = 0; i < 4; i++) begin
            u_core.wr(ADDR_STOP_ENABLE_KEY, KEYS[i]);
            fire(2);
            chk("stop enter", KEYS[i] == STOP_KEY, se);
            chk("stop to reset", KEYS[i] != STOP_KEY, sr);
        end
        for (int s = 0; s < 2; s++) begin
            u_core.wr(ADDR_PWM_CONTROL, s ? 8'h10 : 8'h00);
            fire(3);
            chk("reload on 8-bit", s == 0, dr);
            fire(4);
            chk("reload on 6-bit", s == 1, dr);
        end
        for (int t = 0; t < 2; t++) begin
            a = t ? ADDR_TIMER_ZERO : ADDR_PWM_CONTROL;
            u_core.wr(a, 8'h02);
            fire(t ? 5 : 3);
            rd_chk(a, 8'h03, "pending set");
            chk("irq on", 1, t ? timer_irq : pwm_irq);
            u_core.wr(a, 8'h01);
            idle(3);
            rd_chk(a, 8'h01, "write 1 keeps");
            chk("irq masked", 0, t ? timer_irq : pwm_irq);
            u_core.wr(a, 8'h00);
            rd_chk(a, 8'h00, "write 0 clears");
        end
        u_core.wr(ADDR_PWM_CONTROL, 8'h0C);
        idle(20);
        chk("pwm clear held", 1, pwm_clear);
        chk("pwm run", 1, pwm_run);
        rd_chk(ADDR_PWM_CONTROL, 8'h0C, "clear not auto");
        u_core.wr(ADDR_PWM_CONTROL, 8'h08);
        idle(3);
        ic = 0;
        repeat (200) begin
            @(negedge core_clk);
            ic += (pwm_tick === 1'b1);
        end
        chk("stopped ticks", 0, ic);
        chk("pwm stopped", 0, pwm_run);
        u_core.wr(ADDR_TIMER_ZERO, 8'h08);
        idle(3);
        chk("timer clear held", 1, timer_clear);
        rd_chk(ADDR_TIMER_ZERO, 8'h08, "timer clear not auto");
        for (int c = 3; c >= 0; c--) begin
            u_core.wr(ADDR_PWM_CONTROL, {c[1:0], 6'h04});
            meas(0, PDIV[c]);
            u_core.wr(ADDR_TIMER_ZERO, {c[1:0], 6'h08});
            meas(1, TDIV[c]);
        end
        for (int k = 0; k < 5; k++) begin
            m = (k == 4) ? 2'h2 : k[1:0];
            od = (k == 4);
            u_core.wr(ADDR_PORT_ONE_CONTROL, {od, od, 2'h0, m, m});
            idle(3);
            chk("p1 pull-up", {2{m == 2'h1}}, p1_pull_up);
            chk("p1 pull-down", {2{m == 2'h3}}, p1_pull_down);
            chk("p1 drive", {2{m == 2'h2}}, p1_drive_en);
            chk("p1 open-drain", {2{od}}, p1_open_drain);
        end
        for (int k = 0; k < 8; k++) begin
            m = k[1:0];
            u_core.wr(ADDR_PORT_TWO_HIGH, {1'b0, k[2:0], m, m});
            u_core.wr(ADDR_PORT_TWO_LOW, {4{m}});
            idle(3);
            chk("p6 pull-up", k == 0 || k == 5, p2_pull_up[6]);
            chk("p6 open-drain", k == 5 || k == 6, p2_open_drain[6]);
            chk("p6 analog", k == 2 || k == 3, p2_analog_eight);
            chk("p6 clock out", k == 7, p2_clock_out);
            chk("p6 drive", k >= 4, p2_drive_en[6]);
            chk("p2 pull-up", {6{m == 2'h0}}, p2_pull_up[5:0]);
            chk("p2 drive", {6{m[1]}}, p2_drive_en[5:0]);
            chk("p2 open-drain", {{5{m == 2'h3}}, 1'b0},
                p2_open_drain[5:0]);
            chk("p2 timer out", m == 2'h3, p2_timer_out);
        end
        u_core.wr(ADDR_TIMER_ZERO, 8'h00);
        idle(3);
        chk("timer out off", 0, p2_timer_out);
        u_core.wr(ADDR_PORT_ONE_CONTROL, 8'h0A);
        idle(3);
        chk("p1 outputs", 2'h3, p1_drive_en);
        end_sim();
    end
endmodule
